// ===== design/ece_pkg.sv
/*
  Shared constants, register map and carrier types of the encoder and
  commutation evaluator. Assumes a single 10 MHz drive clock.
*/
package ece_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SER_HALF_NS = 500;
  localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HALL_OFS = 8'h04;
  localparam logic [7:0] OFS_ENC_OFS = 8'h08;
  localparam logic [7:0] OFS_LINES = 8'h0c;
  localparam logic [7:0] OFS_INC_STEP = 8'h10;
  localparam logic [7:0] OFS_POSITION = 8'h14;
  localparam logic [7:0] OFS_ANGLE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_SER_CMD = 8'h20;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_QUAD_EN = 2;
  localparam int CTRL_INDEX_EN = 3;
  localparam int CTRL_HALL_EN = 4;
  localparam int CTRL_PHASE_LEFT = 5;
  localparam int CTRL_SEG_60 = 6;
  localparam int CTRL_MODE_LSB = 7;
  localparam int CTRL_Z0_EN = 9;
  localparam int CTRL_Z1_EN = 10;
  localparam int CTRL_FAULT_EN = 11;
  localparam int CTRL_FAULT_HIGH = 12;
  localparam int CTRL_WIDTH = 13;

  localparam logic [1:0] ENC_DIGITAL = 2'h0;
  localparam logic [1:0] ENC_ANALOG = 2'h1;
  localparam logic [1:0] ENC_SERIAL = 2'h2;
  localparam logic [1:0] MODE_BLOCK = 2'h0;
  localparam logic [1:0] MODE_SINE = 2'h1;
  localparam logic [1:0] MODE_HALL_SINE = 2'h2;

  // status fields
  localparam int ST_FAULT_DIG = 0;
  localparam int ST_FAULT_ANA = 1;
  localparam int ST_COMM_VALID = 2;
  localparam int ST_INDEX_SEEN = 3;
  localparam int ST_SER_BUSY = 4;
  localparam int ST_TP_DONE = 5;
  localparam int ST_AUTO_REQ = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_WIDTH-1:0] CTRL_RST = 13'h009c;
  localparam logic [15:0] HALL_OFS_RST = 16'h0000;
  localparam logic [15:0] ENC_OFS_RST = 16'h0000;
  localparam logic [19:0] LINES_RST = 20'h00800;
  localparam logic [15:0] INC_STEP_RST = 16'h0008;

  // angles, full turn is 2^16
  localparam logic [15:0] ANG_30 = 16'h1555;
  localparam logic [15:0] ANG_60 = 16'h2aab;

  // serial commands
  localparam logic [7:0] CMD_POS = 8'h01;
  localparam logic [7:0] CMD_TYPEPLATE = 8'h02;
  localparam logic [7:0] CMD_NV_RD = 8'h03;
  localparam logic [7:0] CMD_NV_WR = 8'h04;
  localparam logic [4:0] SER_LAST_BIT = 5'h1f;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SER_IDLE, SER_TX, SER_RX} ece_ser_type;

  typedef struct packed {
    logic [1:0] quadrature_track_pair;
    logic [1:0] main_sincos_track;
    logic index;
    logic [2:0] hall;
    logic encoder_fault_input;
    logic ser_dat;
  } ece_pins_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ece_bus_type;

  typedef struct packed {
    logic valid;
    logic [15:0] angle;
  } ece_ctrack_type;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // hall code to sector 0..5, 7 for the two illegal codes
  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    unique case (h)
      3'h1: hall_sector = 3'h0;
      3'h3: hall_sector = 3'h1;
      3'h2: hall_sector = 3'h2;
      3'h6: hall_sector = 3'h3;
      3'h4: hall_sector = 3'h4;
      3'h5: hall_sector = 3'h5;
      default: hall_sector = 3'h7;
    endcase
  endfunction

  // gray step between two track samples; a double jump is dropped
  function automatic logic signed [15:0] quad_step(input logic [1:0] o, input logic [1:0] n);
    logic [1:0] io;
    logic [1:0] in;
    logic [1:0] d;
    io = {o[1], o[1] ^ o[0]};
    in = {n[1], n[1] ^ n[0]};
    d = in - io;
    if (d == 2'h1) begin
      quad_step = 16'sh0001;
    end else if (d == 2'h3) begin
      quad_step = -16'sh0001;
    end else begin
      quad_step = 16'sh0000;
    end
  endfunction
endpackage

// ===== design/ece_evaluator.sv
/*
  Encoder and commutation evaluator: quadrature or sine/cosine track
  counting, index correction, Hall and commutation track angle, fault
  input and a simple serial absolute encoder channel.
  Assumes pins are asynchronous to clk_i; the commutation track angle
  comes from converter logic on clk_i.
*/
// Notes on behaviour
// - quadrature option counts square track signals
// - hall only operation without quadrature track
// - index pulse corrects accumulated counting error
// - index enable bit off ignores index pulses
// - hall state gives start angle within 30 degrees
// - hall boundaries and first index refine angle
// - hall offset added to hall derived angle
// - phase sequence selects hall counting direction
// - hall segment width 120 or 60 degrees
// - block mode takes angle from hall only
// - sine mode corrects once, then incremental
// - hall supported sine corrects every change
// - analogue main track drives incremental count
// - commutation track sets angle after reset
// - no commutation track requests automatic detection
// - reference pulse handled like index pulse
// - serial encoder position moves over serial channel
// - serial line count read from type plate
// - serial nonvolatile memory written and read back
// - four counts per line on both tracks
// - fault input raises digital or analogue error
module ece_evaluator
  import ece_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire ece_bus_type bus_i,
  output logic [31:0] rd_data_o,
  input wire ece_pins_type pins_i,
  input wire ece_ctrack_type commutation_sincos_track_i,
  output logic [31:0] position_o,
  output logic [15:0] comm_angle_o,
  output logic comm_valid_o,
  output logic fault_digital_o,
  output logic fault_analog_o,
  output logic auto_comm_req_o,
  output logic ser_clk_o,
  output logic ser_dat_o,
  output logic ser_dat_oe_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ece_pins_type sync1;
    ece_pins_type sync2;
    ece_pins_type sync3;
    ece_pins_type stab;
    ece_pins_type stab_d;
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [15:0] hall_ofs;
    logic [15:0] enc_ofs;
    logic [19:0] lines;
    logic [15:0] inc_step;
    logic [19:0] tp_lines;
    logic tp_done;
    logic [31:0] position;
    logic [21:0] rev_cnt;
    logic index_seen;
    logic [15:0] angle;
    logic comm_valid;
    logic [2:0] hall_prev;
    logic hall_once;
    logic fault_dig;
    logic fault_ana;
    logic auto_req;
    logic [31:0] rd_data;
    ece_ser_type ser_st;
    logic [2:0] ser_div;
    logic ser_clk;
    logic ser_dat;
    logic ser_oe;
    logic [4:0] ser_bit;
    logic [31:0] ser_sh;
    logic [7:0] ser_cmd;
    logic [31:0] ser_rx;
    logic sw_pend;
    logic [31:0] sw_word;
  } ece_state_type;

  ece_state_type s_reg;
  ece_state_type s_next;

  logic [1:0] enc;
  logic [1:0] mode;
  logic [21:0] cpr;
  logic signed [15:0] delta;
  logic idx_evt;
  logic [2:0] sec;
  logic [15:0] step;
  logic [15:0] center;
  logic hall_chg;
  logic fault_act;
  logic ser_pos_done;
  logic [31:0] corr_pos;

  assign enc = s_reg.ctrl[CTRL_TYPE_LSB +: 2];
  assign mode = s_reg.ctrl[CTRL_MODE_LSB +: 2];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [9:0] agree;
    logic [2:0] raw;
    logic fwd;
    logic [15:0] bound;
    logic signed [32:0] prod;
    logic tick;
    agree = 10'h000;
    raw = 3'h0;
    fwd = 1'b0;
    bound = 16'h0000;
    prod = 33'sh0;
    tick = 1'b0;
    s_next = s_reg;
    ser_pos_done = 1'b0;

    // three stage sampling; second and third must agree
    s_next.sync1 = pins_i;
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    agree = s_reg.sync2 ~^ s_reg.sync3;
    s_next.stab = (agree & s_reg.sync3) | (~agree & s_reg.stab);
    s_next.stab_d = s_reg.stab;

    // register writes
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        OFS_CTRL: s_next.ctrl = bus_i.wdata[CTRL_WIDTH-1:0];
        OFS_HALL_OFS: s_next.hall_ofs = bus_i.wdata[15:0];
        OFS_ENC_OFS: s_next.enc_ofs = bus_i.wdata[15:0];
        OFS_LINES: s_next.lines = bus_i.wdata[19:0];
        OFS_INC_STEP: s_next.inc_step = bus_i.wdata[15:0];
        OFS_STATUS: begin
          if (bus_i.wdata[ST_FAULT_DIG]) begin
            s_next.fault_dig = 1'b0;
          end
          if (bus_i.wdata[ST_FAULT_ANA]) begin
            s_next.fault_ana = 1'b0;
          end
        end
        OFS_SER_CMD: begin
          s_next.sw_pend = 1'b1;
          s_next.sw_word = bus_i.wdata;
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // serial channel: 32 bits out, then 32 bits in
    // ----------------------------------------------------------------
    tick = (s_reg.ser_div == 3'(SER_HALF_CYC - 1));
    s_next.ser_div = tick ? 3'h0 : s_reg.ser_div + 3'h1;
    unique case (s_reg.ser_st)
      SER_IDLE: begin
        s_next.ser_clk = 1'b0;
        s_next.ser_oe = 1'b0;
        if (enc == ENC_SERIAL && tick) begin
          // software commands first, then type plate, then position poll
          if (s_reg.sw_pend) begin
            s_next.ser_sh = s_reg.sw_word;
            s_next.sw_pend = bus_i.wr && bus_i.addr == OFS_SER_CMD;
          end else if (!s_reg.tp_done) begin
            s_next.ser_sh = {CMD_TYPEPLATE, 24'h000000};
          end else begin
            s_next.ser_sh = {CMD_POS, 24'h000000};
          end
          s_next.ser_cmd = s_next.ser_sh[31:24];
          s_next.ser_dat = s_next.ser_sh[31];
          s_next.ser_oe = 1'b1;
          s_next.ser_bit = 5'h00;
          s_next.ser_st = SER_TX;
        end
      end
      SER_TX: begin
        if (tick) begin
          s_next.ser_clk = !s_reg.ser_clk;
          if (s_reg.ser_clk) begin
            if (s_reg.ser_bit == SER_LAST_BIT) begin
              s_next.ser_oe = 1'b0;
              s_next.ser_dat = 1'b0;
              s_next.ser_bit = 5'h00;
              s_next.ser_st = SER_RX;
            end else begin
              s_next.ser_bit = s_reg.ser_bit + 5'h01;
              s_next.ser_sh = {s_reg.ser_sh[30:0], 1'b0};
              s_next.ser_dat = s_reg.ser_sh[30];
            end
          end
        end
      end
      SER_RX: begin
        if (tick) begin
          s_next.ser_clk = !s_reg.ser_clk;
          // sampled late in the bit: the pin path adds four cycles
          if (s_reg.ser_clk) begin
            s_next.ser_sh = {s_reg.ser_sh[30:0], s_reg.stab.ser_dat};
            s_next.ser_bit = s_reg.ser_bit + 5'h01;
            if (s_reg.ser_bit == SER_LAST_BIT) begin
              s_next.ser_rx = s_next.ser_sh;
              s_next.ser_st = SER_IDLE;
              if (s_reg.ser_cmd == CMD_TYPEPLATE) begin
                s_next.tp_lines = s_next.ser_sh[19:0];
                s_next.tp_done = 1'b1;
              end else if (s_reg.ser_cmd == CMD_POS) begin
                ser_pos_done = 1'b1;
              end
            end
          end
        end
      end
      default: s_next.ser_st = SER_IDLE;
    endcase

    // ----------------------------------------------------------------
    // incremental position
    // ----------------------------------------------------------------
    if (enc == ENC_DIGITAL && s_reg.ctrl[CTRL_QUAD_EN]) begin
      delta = quad_step(s_reg.stab_d.quadrature_track_pair,
                        s_reg.stab.quadrature_track_pair);
    end else if (enc == ENC_ANALOG && s_reg.ctrl[CTRL_Z0_EN]) begin
      delta = quad_step(s_reg.stab_d.main_sincos_track,
                        s_reg.stab.main_sincos_track);
    end else if (ser_pos_done) begin
      delta = signed'(s_next.ser_rx[15:0] - s_reg.position[15:0]);
    end else begin
      delta = 16'sh0000;
    end

    if (ser_pos_done) begin
      s_next.position = s_next.ser_rx;
    end else begin
      s_next.position = s_reg.position + {{16{delta[15]}}, delta};
    end
    if (delta == 16'sh0001) begin
      s_next.rev_cnt = (s_reg.rev_cnt >= cpr - 22'h1) ? 22'h0 : s_reg.rev_cnt + 22'h1;
    end else if (delta == -16'sh0001) begin
      s_next.rev_cnt = (s_reg.rev_cnt == 22'h0) ? cpr - 22'h1 : s_reg.rev_cnt - 22'h1;
    end

    // index or reference pulse; ignored when its enable bit is clear
    if (idx_evt) begin
      s_next.rev_cnt = 22'h0;
      if (s_reg.index_seen) begin
        s_next.position = corr_pos;
      end
      s_next.index_seen = 1'b1;
    end

    // ----------------------------------------------------------------
    // commutation angle
    // ----------------------------------------------------------------
    prod = $signed(delta) * $signed({1'b0, s_reg.inc_step});
    raw = s_reg.hall_prev + 3'h1;
    fwd = (raw == 3'h6 ? 3'h0 : raw) == sec;
    bound = s_reg.hall_ofs + 16'((fwd ? sec : s_reg.hall_prev) * step);
    if (!s_reg.comm_valid) begin
      if (s_reg.ctrl[CTRL_HALL_EN] && sec != 3'h7) begin
        s_next.angle = center;
        s_next.comm_valid = 1'b1;
      end else if (enc == ENC_ANALOG && s_reg.ctrl[CTRL_Z1_EN] &&
                   commutation_sincos_track_i.valid) begin
        s_next.angle = commutation_sincos_track_i.angle + s_reg.enc_ofs;
        s_next.comm_valid = 1'b1;
      end
    end else if (mode == MODE_BLOCK && s_reg.ctrl[CTRL_HALL_EN]) begin
      if (sec != 3'h7) begin
        s_next.angle = center;
      end
    end else if (hall_chg && (mode == MODE_HALL_SINE || !s_reg.hall_once)) begin
      s_next.angle = bound;
      s_next.hall_once = 1'b1;
    end else if (idx_evt && !s_reg.index_seen) begin
      s_next.angle = s_reg.enc_ofs;
    end else begin
      s_next.angle = s_reg.angle + prod[15:0];
    end
    if (sec != 3'h7) begin
      s_next.hall_prev = sec;
    end
    s_next.auto_req = (enc == ENC_ANALOG) && !s_reg.ctrl[CTRL_Z1_EN];

    // ----------------------------------------------------------------
    // fault input; a new fault wins over a clear
    // ----------------------------------------------------------------
    if (fault_act && enc == ENC_DIGITAL) begin
      s_next.fault_dig = 1'b1;
    end
    if (fault_act && enc == ENC_ANALOG) begin
      s_next.fault_ana = 1'b1;
    end

    // ----------------------------------------------------------------
    // read data, valid only in the cycle after the strobe
    // ----------------------------------------------------------------
    s_next.rd_data = 32'h0;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        OFS_CTRL: s_next.rd_data = {19'h0, s_reg.ctrl};
        OFS_HALL_OFS: s_next.rd_data = {16'h0, s_reg.hall_ofs};
        OFS_ENC_OFS: s_next.rd_data = {16'h0, s_reg.enc_ofs};
        OFS_LINES: s_next.rd_data = {12'h0, (enc == ENC_SERIAL) ? s_reg.tp_lines : s_reg.lines};
        OFS_INC_STEP: s_next.rd_data = {16'h0, s_reg.inc_step};
        OFS_POSITION: s_next.rd_data = s_reg.position;
        OFS_ANGLE: s_next.rd_data = {16'h0, s_reg.angle};
        OFS_STATUS: begin
          s_next.rd_data[ST_FAULT_DIG] = s_reg.fault_dig;
          s_next.rd_data[ST_FAULT_ANA] = s_reg.fault_ana;
          s_next.rd_data[ST_COMM_VALID] = s_reg.comm_valid;
          s_next.rd_data[ST_INDEX_SEEN] = s_reg.index_seen;
          s_next.rd_data[ST_SER_BUSY] = s_reg.sw_pend || s_reg.ser_st != SER_IDLE;
          s_next.rd_data[ST_TP_DONE] = s_reg.tp_done;
          s_next.rd_data[ST_AUTO_REQ] = s_reg.auto_req;
        end
        OFS_SER_CMD: s_next.rd_data = s_reg.ser_rx;
        default: s_next.rd_data = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shared decode
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] r;
    r = hall_sector(s_reg.stab.hall);
    // left sequence walks the sectors the other way
    if (s_reg.ctrl[CTRL_PHASE_LEFT] && r != 3'h7 && r != 3'h0) begin
      sec = 3'h6 - r;
    end else begin
      sec = r;
    end
    // one state step spans half a hall segment
    step = s_reg.ctrl[CTRL_SEG_60] ? ANG_30 : ANG_60;
    center = s_reg.hall_ofs + 16'(sec * step) + {1'b0, step[15:1]};
    hall_chg = s_reg.ctrl[CTRL_HALL_EN] && sec != 3'h7 && sec != s_reg.hall_prev;
    cpr = {s_reg.ctrl[CTRL_TYPE_LSB +: 2] == ENC_SERIAL ? s_reg.tp_lines : s_reg.lines, 2'b00};
    idx_evt = s_reg.ctrl[CTRL_INDEX_EN] && enc != ENC_SERIAL &&
              s_reg.stab.index && !s_reg.stab_d.index;
    // pull the count back to the nearest whole turn
    if (s_reg.rev_cnt < {1'b0, cpr[21:1]}) begin
      corr_pos = s_reg.position - {10'h0, s_reg.rev_cnt};
    end else begin
      corr_pos = s_reg.position + {10'h0, cpr - s_reg.rev_cnt};
    end
    fault_act = s_reg.ctrl[CTRL_FAULT_EN] &&
                (s_reg.stab.encoder_fault_input == s_reg.ctrl[CTRL_FAULT_HIGH]);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.hall_ofs <= HALL_OFS_RST;
      s_reg.enc_ofs <= ENC_OFS_RST;
      s_reg.lines <= LINES_RST;
      s_reg.inc_step <= INC_STEP_RST;
      s_reg.hall_prev <= 3'h7;
      s_reg.ser_st <= SER_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_o = s_reg.rd_data;
  assign position_o = s_reg.position;
  assign comm_angle_o = s_reg.angle;
  assign comm_valid_o = s_reg.comm_valid;
  assign fault_digital_o = s_reg.fault_dig;
  assign fault_analog_o = s_reg.fault_ana;
  assign auto_comm_req_o = s_reg.auto_req;
  assign ser_clk_o = s_reg.ser_clk;
  assign ser_dat_o = s_reg.ser_dat;
  assign ser_dat_oe_o = s_reg.ser_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_fault_dig_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fault_act && enc == ENC_DIGITAL |=> fault_digital_o)
    else $error("digital fault not raised");
  chk_quad_count_up: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enc == ENC_DIGITAL && s_reg.ctrl[CTRL_QUAD_EN] && !idx_evt &&
    s_reg.stab_d.quadrature_track_pair == 2'h0 && s_reg.stab.quadrature_track_pair == 2'h1
    |=> position_o == $past(position_o) + 32'h1)
    else $error("quadrature edge not counted");
  chk_block_hall_angle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    comm_valid_o && mode == MODE_BLOCK && s_reg.ctrl[CTRL_HALL_EN] && sec != 3'h7
    |=> comm_angle_o == $past(center))
    else $error("block angle not from hall");
  chk_index_correct: assert property (@(posedge clk_i) disable iff (!nrst_i)
    idx_evt && s_reg.index_seen |=> position_o == $past(corr_pos) && s_reg.rev_cnt == 22'h0)
    else $error("index correction wrong");
  chk_index_ignored: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !s_reg.ctrl[CTRL_INDEX_EN] && enc == ENC_DIGITAL && !s_reg.ctrl[CTRL_QUAD_EN]
    |=> $stable(position_o))
    else $error("position moved with index ignored");
  chk_hall_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !comm_valid_o && s_reg.ctrl[CTRL_HALL_EN] && sec != 3'h7
    |=> comm_valid_o && comm_angle_o == $past(center))
    else $error("hall start angle missing");
  chk_serial_turnaround: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_reg.ser_st == SER_RX |-> !ser_dat_oe_o)
    else $error("driving line while receiving");
  chk_typeplate_lines: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_reg.ser_st == SER_RX && s_next.ser_st == SER_IDLE && s_reg.ser_cmd == CMD_TYPEPLATE
    |=> s_reg.tp_done && s_reg.tp_lines == s_reg.ser_rx[19:0])
    else $error("type plate lines not taken");
endmodule

// ===== tb/ece_enc_model.sv
/*
  Behavioural serial absolute encoder on the far side of the evaluator.
  Assumes the drive owns the line while ser_dat_oe_i is high and clocks it.
*/
module ece_enc_model
  import ece_pkg::*;
#(
  parameter logic [31:0] PLATE = 32'h00001000,
  parameter logic [31:0] POS_VAL = 32'h00012345
)(
  input wire logic ser_clk_i,
  input wire logic ser_dat_i,
  input wire logic ser_dat_oe_i,
  output logic ser_dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] got = '0;
  logic [31:0] ans = '0;
  logic [15:0] nv = '0;
  initial ser_dat_o = 1'b0;
  // drive changes data on the fall, so the rise sees it settled
  always @(posedge ser_clk_i) begin
    if (ser_dat_oe_i) begin
      got = {got[30:0], ser_dat_i};
    end else begin
      ser_dat_o = ans[31];
      ans = {ans[30:0], ~ans[31]};
    end
  end
  always @(negedge ser_dat_oe_i) begin
    if (got[31:24] == CMD_NV_WR) begin
      nv = got[15:0];
    end
    if (got[31:24] == CMD_NV_RD) begin
      ans = {16'h0000, nv};
    end else if (got[31:24] == CMD_POS) begin
      ans = POS_VAL;
    end else begin
      ans = PLATE;
    end
    ser_dat_o = ~ser_dat_o;
  end
endmodule

// ===== tb/ece_evaluator_tb.sv
/*
  Self-checking bench of the encoder evaluator: register port, tracks,
  index, fault input and serial channel against the encoder model.
  Assumes the 10 MHz clock and synchronous low reset of the design.
*/
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module ece_evaluator_tb import ece_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] SEQ [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  ece_bus_type bus = '0;
  ece_pins_type pv = '{hall: 3'h1, default: '0};
  ece_pins_type pin_bus;
  ece_ctrack_type ct = '0;
  logic [31:0] rdat, pos, d;
  logic [15:0] ang;
  logic cv, fd, fa, areq, sclk, sdo, soe, mdo;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  // line level: the drive wins while it enables, else the encoder
  assign pin_bus = {pv[9:1], soe ? sdo : mdo};
  ece_evaluator dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus), .rd_data_o(rdat),
    .pins_i(pin_bus), .commutation_sincos_track_i(ct), .position_o(pos),
    .comm_angle_o(ang), .comm_valid_o(cv), .fault_digital_o(fd), .fault_analog_o(fa),
    .auto_comm_req_o(areq), .ser_clk_o(sclk), .ser_dat_o(sdo), .ser_dat_oe_o(soe));
  ece_enc_model enc_u (.ser_clk_i(sclk), .ser_dat_i(sdo), .ser_dat_oe_i(soe),
    .ser_dat_o(mdo));
  // ----------------------------------------------------------------
  // bus and pin tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic idx();
    @(posedge clk_i);
    pv.index <= 1'b1;
    repeat (8) @(posedge clk_i);
    pv.index <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // eight gray steps forward, slow enough for the pin synchronisers
  task automatic steps8();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      pv.quadrature_track_pair <= SEQ[i%4];
      pv.main_sincos_track <= SEQ[i%4];
      repeat (5) @(posedge clk_i);
    end
    repeat (5) @(posedge clk_i);
  endtask
  // position polls run back to back: catch the queued frame, then its answer
  task automatic ser_frame();
    @(posedge clk_i);
    @(posedge soe);
    @(negedge soe);
    repeat (330) @(posedge clk_i);
  endtask
  task automatic close_out();
    $display("compares %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      miscompares++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(OFS_CTRL); `CHK("ctrl", 32'h0000009c, d)
    rd(OFS_LINES); `CHK("lines", 32'h00000800, d)
    rd(OFS_INC_STEP); `CHK("step", 32'h00000008, d)
    rd(8'h40); `CHK("unmapped", 32'h0, d)
    `CHK("start angle", ANG_30, ang)
    `CHK("angle valid", 1'b1, cv)
    steps8();
    rd(OFS_POSITION); `CHK("position", 32'h00000008, d)
    wr(OFS_CTRL, 32'h00000094);
    idx();
    rd(OFS_STATUS); `CHK("index seen", 1'b0, d[ST_INDEX_SEEN])
    rd(OFS_POSITION); `CHK("position", 32'h00000008, d)
    wr(OFS_CTRL, 32'h0000009c);
    idx();
    steps8();
    idx();
    rd(OFS_STATUS); `CHK("index seen", 1'b1, d[ST_INDEX_SEEN])
    rd(OFS_POSITION); `CHK("snapped", 32'h00000008, d)
    // hall only, left sequence, 60 degree segments, then hall supported sine
    wr(OFS_HALL_OFS, 32'h00000100);
    wr(OFS_CTRL, 32'h00000070);
    pv.hall <= 3'h3;
    repeat (8) @(posedge clk_i);
    `CHK("block angle", 16'h0100 + 16'(5 * ANG_30) + (ANG_30 >> 1), ang)
    wr(OFS_CTRL, 32'h00000170);
    pv.hall <= 3'h2;
    repeat (8) @(posedge clk_i);
    `CHK("hall edge", 16'h0100 + 16'(5 * ANG_30), ang)
    pv.hall <= 3'h6;
    repeat (8) @(posedge clk_i);
    `CHK("hall edge", 16'h0100 + 16'(4 * ANG_30), ang)
    wr(OFS_CTRL, 32'h0000189c);
    pv.encoder_fault_input <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK("fault dig", 1'b1, fd)
    `CHK("fault ana", 1'b0, fa)
    pv.encoder_fault_input <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(OFS_STATUS, 32'h00000001);
    @(posedge clk_i);
    `CHK("fault clear", 1'b0, fd)
    wr(OFS_CTRL, 32'h00001a01);
    pv.encoder_fault_input <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK("fault ana", 1'b1, fa)
    `CHK("auto req", 1'b1, areq)
    // the track angle is only taken while no angle is valid, so reset first
    ct <= '{1'b1, 16'h4321};
    pv.hall <= 3'h0;
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    wr(OFS_ENC_OFS, 32'h00000200);
    wr(OFS_CTRL, 32'h00001e09);
    repeat (4) @(posedge clk_i);
    `CHK("auto req", 1'b0, areq)
    `CHK("track valid", 1'b1, cv)
    `CHK("track angle", 16'h4521, ang)
    idx();
    `CHK("ref angle", 16'h0200, ang)
    steps8();
    rd(OFS_POSITION); `CHK("main track", 32'h00000008, d)
    // a frame is 64 bits of 10 clocks; one pending frame may precede
    wr(OFS_CTRL, 32'h0000009e);
    repeat (1400) @(posedge clk_i);
    rd(OFS_LINES); `CHK("plate lines", 32'h00001000, d)
    rd(OFS_POSITION); `CHK("ser position", 32'h00012345, d)
    wr(OFS_SER_CMD, {CMD_NV_WR, 8'h05, 16'hbeef});
    ser_frame();
    wr(OFS_SER_CMD, {CMD_NV_RD, 8'h05, 16'h0000});
    ser_frame();
    rd(OFS_SER_CMD); `CHK("nv back", 32'h0000beef, d)
    close_out();
  end
endmodule
